// ===== core/bmhe_engine.sv
/*
  Block-transfer engine with host-fed monochrome source, APB registers, pixel write port.
  Assumes destination pixels read as zero (no read port) and APB master per AMBA.
*/
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module bmhe_engine #(
  parameter int DIM_W = 13
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output bmhe_pkg::bmhe_pix_s pix_out,
  output logic             busy
);
  // Field slices are fixed by the register layout
  if (DIM_W != bmhe_pkg::FIELD_LO_HI + 1) begin : g_dim_check
    $error("DIM_W must match the extent field width");
  end

  typedef enum logic [1:0] {BMHE_IDLE, BMHE_WAIT, BMHE_DRAW} bmhe_state_e;

  logic [7:0]  config_q;
  logic [31:0] control_q;
  logic [31:0] mono_q;
  logic [31:0] pitch_q;
  logic [31:0] fgcol_q;
  logic [31:0] srcadr_q;
  logic [31:0] dstadr_q;
  logic [31:0] extent_q;
  bmhe_state_e state_q;
  logic [7:0]  src_byte_q;
  logic [2:0]  bit_q;
  logic [DIM_W-1:0] col_q;
  logic [DIM_W-1:0] row_q;
  logic [22:0] line_q;
  logic [22:0] addr_q;
  bmhe_pkg::bmhe_pix_s pix_q;

  logic        acc;
  logic        wr;
  logic        addr_ok;
  logic        data_acc;
  logic        start;
  logic        src_bit;
  logic        host_mono;
  logic        mask_mode;
  logic        last_col;
  logic        last_row;
  logic [7:0]  rop_res;
  logic [DIM_W-1:0] width;
  logic [DIM_W-1:0] new_width;
  logic [DIM_W-1:0] height;
  logic [DIM_W-1:0] dpitch;

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign addr_ok  = (paddr <= bmhe_pkg::OFF_DATA) && (paddr[1:0] == 2'b00);
  assign width    = extent_q[bmhe_pkg::FIELD_LO_HI:0];
  assign new_width = pwdata[bmhe_pkg::FIELD_LO_HI:0];
  assign height   = extent_q[bmhe_pkg::FIELD_HI:bmhe_pkg::FIELD_LO_TOP];
  // Destination pitch only; source pitch bits unused for mono source
  assign dpitch   = pitch_q[bmhe_pkg::FIELD_HI:bmhe_pkg::FIELD_LO_TOP];
  // Host data port accepted only while waiting for a source byte
  assign data_acc = wr && (paddr == bmhe_pkg::OFF_DATA) && (state_q == BMHE_WAIT);
  assign start    = wr && (paddr == bmhe_pkg::OFF_EXTENT) && !busy &&
                    (pwdata[bmhe_pkg::FIELD_HI:bmhe_pkg::FIELD_LO_TOP] != '0);
  assign host_mono = control_q[bmhe_pkg::CTL_MONO] & control_q[bmhe_pkg::CTL_HOSTSRC];
  assign mask_mode = control_q[bmhe_pkg::CTL_MONOMASK] &&
                     (control_q[bmhe_pkg::CTL_MASKSEL_HI:bmhe_pkg::CTL_MASKSEL_LO] == 3'b000);
  // Left-most pixel in the byte's high bit, first byte is top-left
  assign src_bit  = host_mono ? src_byte_q[3'd7 - bit_q] : 1'b1;
  assign last_col = (col_q == width - 1'b1);
  assign last_row = (row_q == height - 1'b1);
  assign busy     = (state_q != BMHE_IDLE);

  // Pattern operand tied off: no pattern fetch, pattern field unused
  bmhe_rop u_rop (
    .rop (control_q[7:0]),
    .pat (8'h00),
    .src (src_bit ? fgcol_q[7:0] : 8'h00),
    .dst (8'h00),
    .res (rop_res)
  );

  assign pready  = 1'b1;
  assign pslverr = acc & ~addr_ok;

  always_comb begin
    prdata = '0;
    if (psel && !pwrite) begin
      unique case (paddr)
        bmhe_pkg::OFF_CONFIG:  prdata = {24'h000000, config_q[7:1], busy};
        bmhe_pkg::OFF_CONTROL: prdata = {busy, control_q[30:0]};
        bmhe_pkg::OFF_MONO:    prdata = mono_q;
        bmhe_pkg::OFF_PITCH:   prdata = pitch_q;
        bmhe_pkg::OFF_FGCOL:   prdata = fgcol_q;
        bmhe_pkg::OFF_SRCADR:  prdata = srcadr_q;
        bmhe_pkg::OFF_DSTADR:  prdata = dstadr_q;
        bmhe_pkg::OFF_EXTENT:  prdata = extent_q;
        default:               prdata = '0;
      endcase
    end
  end

  // Register writes; config 00h gives 8bpp normal mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q  <= 8'h00;
      control_q <= bmhe_pkg::RESET_WORD;
      mono_q    <= bmhe_pkg::RESET_WORD;
      pitch_q   <= bmhe_pkg::RESET_WORD;
      fgcol_q   <= bmhe_pkg::RESET_WORD;
      srcadr_q  <= bmhe_pkg::RESET_WORD;
      dstadr_q  <= bmhe_pkg::RESET_WORD;
      extent_q  <= bmhe_pkg::RESET_WORD;
    end else if (wr && !busy) begin
      unique case (paddr)
        bmhe_pkg::OFF_CONFIG:  config_q  <= {pwdata[7:1], 1'b0};
        bmhe_pkg::OFF_CONTROL: control_q <= {1'b0, pwdata[30:0]};
        // Alignment and clip fields stored; zero clip means whole source used
        bmhe_pkg::OFF_MONO:    mono_q    <= pwdata;
        bmhe_pkg::OFF_PITCH:   pitch_q   <= pwdata;
        bmhe_pkg::OFF_FGCOL:   fgcol_q   <= pwdata;
        bmhe_pkg::OFF_SRCADR:  srcadr_q  <= pwdata;
        bmhe_pkg::OFF_DSTADR:  dstadr_q  <= pwdata;
        bmhe_pkg::OFF_EXTENT:  extent_q  <= pwdata;
        default: ;
      endcase
    end
  end

  // Sequencer: in host mono mode wait for a host byte, then draw up to eight pixels from it; each row starts a new byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= BMHE_IDLE;
      src_byte_q <= 8'h00;
      bit_q      <= 3'd0;
      col_q      <= '0;
      row_q      <= '0;
      line_q     <= '0;
      addr_q     <= '0;
    end else begin
      unique case (state_q)
        BMHE_IDLE: begin
          if (start) begin
            state_q <= (new_width == '0) ? BMHE_IDLE : (host_mono ? BMHE_WAIT : BMHE_DRAW);
            line_q  <= dstadr_q[bmhe_pkg::ADDR_HI:0];
            addr_q  <= dstadr_q[bmhe_pkg::ADDR_HI:0];
            col_q   <= '0;
            row_q   <= '0;
            bit_q   <= 3'd0;
          end
        end
        BMHE_WAIT: begin
          if (data_acc) begin
            src_byte_q <= pwdata[7:0];
            state_q    <= BMHE_DRAW;
          end
        end
        BMHE_DRAW: begin
          bit_q  <= bit_q + 3'd1;
          addr_q <= addr_q + 23'd1;
          col_q  <= col_q + 1'b1;
          if (last_col) begin
            col_q  <= '0;
            bit_q  <= 3'd0;
            row_q  <= row_q + 1'b1;
            line_q <= line_q + {10'd0, dpitch};
            addr_q <= line_q + {10'd0, dpitch};
            if (last_row) state_q <= BMHE_IDLE;
            else if (host_mono) state_q <= BMHE_WAIT;
          end else if (host_mono && bit_q == 3'd7) begin
            state_q <= BMHE_WAIT;
          end
        end
        default: state_q <= BMHE_IDLE;
      endcase
    end
  end

  // Pixel writes; masked background pixels are not written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_q <= '0;
    end else begin
      pix_q.valid <= (state_q == BMHE_DRAW) && !(mask_mode && !src_bit);
      pix_q.addr  <= addr_q;
      pix_q.data  <= rop_res;
    end
  end
  assign pix_out = pix_q;

  // Checks on busy, geometry, pixel port and host data
  a_busy_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && paddr == bmhe_pkg::OFF_CONFIG)
    |-> prdata[bmhe_pkg::CFG_BUSY_BIT] == (state_q != BMHE_IDLE))
    else $error("Config busy bit wrong");

  a_ctl_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && paddr == bmhe_pkg::OFF_CONTROL)
    |-> prdata[bmhe_pkg::CTL_BUSY_BIT] == (state_q != BMHE_IDLE))
    else $error("Control busy bit wrong");

  a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && busy && paddr == bmhe_pkg::OFF_FGCOL)
    |=> fgcol_q == $past(fgcol_q))
    else $error("Register changed while busy");

  a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (start && new_width != '0)
    |=> busy)
    else $error("Start did not raise busy");

  a_zero_height: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !busy && paddr == bmhe_pkg::OFF_EXTENT &&
     pwdata[bmhe_pkg::FIELD_HI:bmhe_pkg::FIELD_LO_TOP] == '0)
    |=> !busy)
    else $error("Zero height started");

  a_busy_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy)
    |-> $past(start))
    else $error("Busy rose without start");

  a_first_addr: assert property (@(posedge pclk) disable iff (!presetn)
    start
    |=> addr_q == $past(dstadr_q[bmhe_pkg::ADDR_HI:0]))
    else $error("First address wrong");

  a_first_line: assert property (@(posedge pclk) disable iff (!presetn)
    start
    |=> line_q == $past(dstadr_q[bmhe_pkg::ADDR_HI:0]) && col_q == '0 && row_q == '0)
    else $error("Start position wrong");

  a_col_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && !last_col)
    |=> addr_q == $past(addr_q) + 23'd1 && col_q == $past(col_q) + 1'b1)
    else $error("Column step wrong");

  a_pitch_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && last_col && !last_row)
    |=> line_q == $past(line_q) + {10'd0, $past(dpitch)})
    else $error("Pitch step wrong");

  a_row_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && last_col && !last_row)
    |=> addr_q == line_q && col_q == '0 && row_q == $past(row_q) + 1'b1)
    else $error("Row start wrong");

  a_idle_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && last_col && last_row)
    |=> !busy)
    else $error("Busy after last pixel");

  a_busy_draws: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && !(last_col && last_row))
    |=> busy)
    else $error("Busy dropped early");

  a_pix_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW)
    |=> pix_out.addr == $past(addr_q))
    else $error("Pixel address wrong");

  a_no_pix_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q != BMHE_DRAW)
    |=> !pix_out.valid)
    else $error("Pixel written outside draw");

  a_mask_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && mask_mode && !src_bit)
    |=> !pix_out.valid)
    else $error("Masked pixel written");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && mask_mode && src_bit)
    |=> pix_out.valid)
    else $error("Foreground pixel dropped");

  a_copy_fg: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && control_q[7:0] == bmhe_pkg::ROP_SRCCOPY && src_bit)
    |=> pix_out.data == $past(fgcol_q[7:0]))
    else $error("Copy colour wrong");

  a_solid_fill: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && !host_mono)
    |=> pix_out.valid)
    else $error("Solid pixel skipped");

  a_wait_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_WAIT && !data_acc)
    |=> state_q == BMHE_WAIT)
    else $error("Drew without host byte");

  a_wait_host: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_WAIT)
    |-> host_mono)
    else $error("Waiting without host source");

  a_take_byte: assert property (@(posedge pclk) disable iff (!presetn)
    data_acc
    |=> state_q == BMHE_DRAW && src_byte_q == $past(pwdata[7:0]))
    else $error("Host byte not taken");

  a_first_bit: assert property (@(posedge pclk) disable iff (!presetn)
    data_acc
    |=> src_bit == $past(pwdata[7]))
    else $error("First pixel not left-most bit");

  a_row_refill: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == BMHE_DRAW && host_mono && last_col && !last_row)
    |=> state_q == BMHE_WAIT && bit_q == 3'd0)
    else $error("Row did not start a new byte");
endmodule // bmhe_engine

// ===== core/bmhe_pkg.sv
/*
  Shared constants and carrier types for the mono host-expansion block-transfer engine.
  Assumes an APB register port and a simple write-only frame-buffer pixel port.
*/
package bmhe_pkg;
  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_MONO    = 8'h08;
  localparam logic [7:0] OFF_PITCH   = 8'h0C;
  localparam logic [7:0] OFF_FGCOL   = 8'h10;
  localparam logic [7:0] OFF_SRCADR  = 8'h14;
  localparam logic [7:0] OFF_DSTADR  = 8'h18;
  localparam logic [7:0] OFF_EXTENT  = 8'h1C;
  localparam logic [7:0] OFF_DATA    = 8'h20;
  localparam int CFG_BUSY_BIT   = 0;
  localparam int CFG_DEPTH_LO   = 4;
  localparam int CTL_BUSY_BIT   = 31;
  localparam int CTL_PAT_HI     = 22;
  localparam int CTL_PAT_LO     = 17;
  localparam int CTL_MASKSEL_HI = 16;
  localparam int CTL_MASKSEL_LO = 14;
  localparam int CTL_MONOMASK   = 13;
  localparam int CTL_MONO       = 12;
  localparam int CTL_HOSTSRC    = 10;
  localparam int CTL_START_HI   = 9;
  localparam int CTL_START_LO   = 8;
  localparam int MONO_FGSEL     = 27;
  localparam int FIELD_HI       = 28;
  localparam int FIELD_LO_TOP   = 16;
  localparam int FIELD_LO_HI    = 12;
  localparam int ADDR_HI        = 22;
  localparam logic [7:0] ROP_SRCCOPY = 8'hCC;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic        valid;
    logic [22:0] addr;
    logic [7:0]  data;
  } bmhe_pix_s;
endpackage

// ===== core/bmhe_rop.sv
/*
  Bit-wise three-operand raster operation on one 8-bit pixel.
  Assumes purely combinational use by the engine.
*/
`timescale 1ns/1ns
module bmhe_rop (
  input  wire logic [7:0] rop,
  input  wire logic [7:0] pat,
  input  wire logic [7:0] src,
  input  wire logic [7:0] dst,
  output logic      [7:0] res
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // Operand bits index the code: pattern high, source, destination low
      assign res[i] = rop[{pat[i], src[i], dst[i]}];
    end
  endgenerate
endmodule // bmhe_rop

// ===== testbench/bmhe_host.sv
/*
  Host CPU model: APB master that programs the engine and feeds source bytes.
  Assumes one clock, pready sampled at rising edges.
*/
`timescale 1ns/1ns
module bmhe_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One APB transfer, released bus shows inverted values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask
  // Poll until idle before programming
  task automatic idle_wait;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 1000; i++) begin
      rd(bmhe_pkg::OFF_CONFIG, r, e);
      if (r[0] === 1'b0) break;
    end
  endtask
endmodule // bmhe_host

// ===== testbench/tb_top.sv
/*
  Self-checking bench: host model drives APB, pixel port is collected and judged.
  Assumes zero-wait APB slave and eight draw cycles per source byte.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                busy;
  bmhe_pkg::bmhe_pix_s pix;
  logic [30:0]         pq[$];
  int                  failures = 0;
  int                  checked = 0;
  bmhe_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  bmhe_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pix_out(pix), .busy(busy));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (pix.valid === 1'b1) pq.push_back({pix.addr, pix.data});
  end
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic test_reset;
    logic [31:0] r;
    logic        e;
    host.rd(bmhe_pkg::OFF_CONFIG, r, e);
    `CHK("config", 32'h0000_0000, r)
    host.rd(bmhe_pkg::OFF_CONTROL, r, e);
    `CHK("control", 32'h0000_0000, r)
    `CHK("pix idle", 1'b0, pix.valid)
    `CHK("ready", 1'b1, pready)
    $display("test_reset done");
  endtask
  task automatic test_mask_copy;
    logic [7:0]  rows [2];
    logic [31:0] r;
    logic        e;
    logic [30:0] got;
    rows = '{8'hA5, 8'h3C};
    host.idle_wait();
    host.wr(bmhe_pkg::OFF_CONFIG, 32'h0000_0000);
    host.wr(bmhe_pkg::OFF_CONTROL, 32'h007E_34CC);
    host.wr(bmhe_pkg::OFF_MONO, 32'h0500_0000);
    host.wr(bmhe_pkg::OFF_PITCH, 32'h0400_1FFF);
    host.wr(bmhe_pkg::OFF_FGCOL, 32'h00AB_CD5A);
    host.wr(bmhe_pkg::OFF_SRCADR, 32'h007F_FFFF);
    host.wr(bmhe_pkg::OFF_DSTADR, 32'h0002_0080);
    pq.delete();
    host.wr(bmhe_pkg::OFF_EXTENT, 32'h0002_0008);
    host.rd(bmhe_pkg::OFF_CONTROL, r, e);
    `CHK("control busy", 32'h807E_34CC, r)
    host.rd(bmhe_pkg::OFF_CONFIG, r, e);
    `CHK("config busy", 32'h0000_0001, r)
    host.wr(bmhe_pkg::OFF_FGCOL, 32'h0000_0011);
    for (int i = 0; i < 2; i++) begin
      `CHK("busy", 1'b1, busy)
      host.wr(bmhe_pkg::OFF_DATA, {24'h000000, rows[i]});
      repeat (12) @(posedge pclk);
    end
    host.idle_wait();
    `CHK("busy end", 1'b0, busy)
    `CHK("pixel count", 8, pq.size())
    for (int i = 0; i < 2; i++) begin
      for (int c = 0; c < 8; c++) begin
        if (rows[i][7 - c]) begin
          got = (pq.size() != 0) ? pq.pop_front() : 31'h7FFF_FFFF;
          `CHK("pixel", {23'(32'h20080 + i * 32'h400 + c), 8'h5A}, got)
        end
      end
    end
    $display("test_mask_copy done");
  endtask
  task automatic test_solid_fill;
    logic [30:0] got;
    host.idle_wait();
    host.wr(bmhe_pkg::OFF_CONTROL, 32'h0000_00CC);
    host.wr(bmhe_pkg::OFF_PITCH, 32'h0400_0000);
    host.wr(bmhe_pkg::OFF_FGCOL, 32'h0000_0077);
    host.wr(bmhe_pkg::OFF_DSTADR, 32'h0000_0100);
    pq.delete();
    host.wr(bmhe_pkg::OFF_EXTENT, 32'h0002_0002);
    host.idle_wait();
    repeat (2) @(posedge pclk);
    `CHK("solid count", 4, pq.size())
    for (int i = 0; i < 4; i++) begin
      got = (pq.size() != 0) ? pq.pop_front() : 31'h7FFF_FFFF;
      `CHK("solid pixel", {23'(32'h100 + (i / 2) * 32'h400 + (i % 2)), 8'h77}, got)
    end
    $display("test_solid_fill done");
  endtask
  task automatic test_no_start;
    logic [31:0] r;
    logic        e;
    host.wr(bmhe_pkg::OFF_EXTENT, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    `CHK("no start", 1'b0, busy)
    host.rd(8'h40, r, e);
    `CHK("unmapped err", 1'b1, e)
    $display("test_no_start done");
  endtask
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_mask_copy();
    test_solid_fill();
    test_no_start();
    stop_test();
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule // tb_top
